// File: mpsm_module_state_machine.sv
// Module state machine with register port and power sequencing outputs
//
// The address-and-strobe port and the register addresses were decided locally.
`include "mpsm_map.svh"
`timescale 1ns/100ps
`default_nettype none

module mpsm_module_state_machine (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire mpsm_pkg::mpsm_pins_s pins,
    input  wire mpsm_pkg::mpsm_req_s  req,
    output var  logic [31:0]        rdata,
    output var  mpsm_pkg::mpsm_ctl_s  ctl
);
    import mpsm_pkg::*;

    // Advertised maximum power byte, value is arbitrary
    localparam logic [7:0] MAX_POWER_ADV = `MPSM_MAXPWR_RST;

    typedef struct packed {
        logic [1:0]  rst_s;
        logic [1:0]  lp_s;
        logic [1:0]  lpx_s;
        logic [1:0]  pwr_s;
        logic [2:0]  lclk_s;
        mpsm_state_e st;
        logic [15:0] cnt;
        logic        flag;
        logic        soft_rst;
        logic [7:0]  link_cnt;
        logic [31:0] rdata;
        mpsm_ctl_s   ctl;
    } mpsm_reg_s;

    mpsm_reg_s r;
    mpsm_reg_s n;
    logic [1:0] rst_sync;
    logic       rst_q;
    logic       rst_term;
    logic       lp_term;
    logic       lpx_term;
    logic       resp;
    logic       flag_set;
    logic       flag_clr;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------

    // Two-stage release of the asynchronous reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_q = rst_sync[1];

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------

    // Request terms after synchronisers
    assign rst_term = r.rst_s[1] | r.soft_rst;
    assign lp_term  = r.lp_s[1];
    assign lpx_term = r.lpx_s[1];
    assign resp     = r.st[3] | r.st[4] | r.st[5] | r.st[6];

    always_comb begin
        n = r;
        // Pin synchronisers; stage 0 feeds stage 1 only
        n.rst_s  = {r.rst_s[0], pins.reset_request_term};
        n.lp_s   = {r.lp_s[0], pins.low_power_request_term};
        n.lpx_s  = {r.lpx_s[0], pins.low_power_exit_request_term};
        n.pwr_s  = {r.pwr_s[0], pins.power_good};
        n.lclk_s = {r.lclk_s[1:0], pins.link_clk};
        flag_set = 1'b0;
        flag_clr = 1'b0;
        n.rdata  = 32'h0000_0000;
        if (r.cnt != 16'h0000) begin
            n.cnt = r.cnt - 16'h0001;
        end
        // Count link clock rises while the link answers
        if (resp && r.lclk_s[1] && !r.lclk_s[2]) begin
            n.link_cnt = r.link_cnt + 8'h01;
        end

        // State transitions
        case (r.st)
            MPSM_RESETTING: begin
                if (r.cnt == 16'h0000) begin
                    n.st = MPSM_RESET;
                end
            end
            MPSM_RESET: begin
                n.soft_rst = 1'b0;
                if (!r.rst_s[1] && r.pwr_s[1]) begin
                    n.st  = MPSM_INIT;
                    n.cnt = `MPSM_CYC(`MPSM_T_INIT_NS);
                end
            end
            MPSM_INIT: begin
                n.flag     = 1'b0;
                n.soft_rst = 1'b0;
                n.link_cnt = 8'h00;
                if (r.cnt == 16'h0000) begin
                    n.st = MPSM_LOWPWR;
                end
            end
            MPSM_LOWPWR: begin
                if (!lp_term) begin
                    n.st  = MPSM_PWRUP;
                    n.cnt = `MPSM_CYC(`MPSM_T_PWRUP_NS);
                end
            end
            MPSM_PWRUP: begin
                if (lp_term) begin
                    n.st  = MPSM_PWRDN;
                    n.cnt = `MPSM_CYC(`MPSM_T_PWRDN_NS);
                end else if (r.cnt == 16'h0000) begin
                    n.st = MPSM_READY;
                end
            end
            MPSM_READY: begin
                if (lpx_term) begin
                    n.st  = MPSM_PWRDN;
                    n.cnt = `MPSM_CYC(`MPSM_T_PWRDN_NS);
                end
            end
            MPSM_PWRDN: begin
                if (r.cnt == 16'h0000) begin
                    n.st = MPSM_LOWPWR;
                end
            end
            default: begin
                n.st = MPSM_RESET;
            end
        endcase

        if (rst_term && r.st != MPSM_RESET && r.st != MPSM_RESETTING) begin
            n.st  = MPSM_RESETTING;
            n.cnt = `MPSM_CYC(`MPSM_T_SHUTDOWN_NS);
        end

        // register port served only while responsive
        if (resp && req.wr) begin
            case (req.addr)
                `MPSM_OFS_FLAG: flag_clr = req.wdata[`MPSM_FLAG_CHG_BIT];
                `MPSM_OFS_CTRL: n.soft_rst = req.wdata[`MPSM_CTRL_SRST_BIT];
                default: begin
                end
            endcase
        end
        // reads answer zero while not responsive
        if (resp && req.rd) begin
            case (req.addr)
                `MPSM_OFS_STATE:  n.rdata = {29'h0, r.ctl.module_state};
                `MPSM_OFS_FLAG:   n.rdata = {31'h0, r.flag};
                `MPSM_OFS_CTRL:   n.rdata = {31'h0, r.soft_rst};
                `MPSM_OFS_MAXPWR: n.rdata = {24'h0, MAX_POWER_ADV};
                `MPSM_OFS_LINK:   n.rdata = {24'h0, r.link_cnt};
                default:          n.rdata = 32'h0000_0000;
            endcase
        end

        // flag on low-power entry only while the low-power request holds
        if (n.st == MPSM_LOWPWR && r.st != MPSM_LOWPWR && lp_term) begin
            flag_set = 1'b1;
        end
        if (n.st == MPSM_READY && r.st != MPSM_READY) begin
            flag_set = 1'b1;
        end
        // Set wins over a clear in the same cycle
        if (n.st != MPSM_INIT) begin
            n.flag = (r.flag & ~flag_clr) | flag_set;
        end

        case (n.st)
            MPSM_INIT:   n.ctl.module_state = `MPSM_CODE_INIT; // Default code
            MPSM_LOWPWR: n.ctl.module_state = `MPSM_CODE_LOWPWR;
            MPSM_PWRUP:  n.ctl.module_state = `MPSM_CODE_PWRUP;
            MPSM_READY:  n.ctl.module_state = `MPSM_CODE_READY;
            MPSM_PWRDN:  n.ctl.module_state = `MPSM_CODE_PWRDN;
            default:     n.ctl.module_state = r.ctl.module_state;
        endcase
        // high power only powering up or operational
        n.ctl.high_power_en     = (n.st == MPSM_PWRUP) || (n.st == MPSM_READY);
        // electronics and interrupts held in reset
        n.ctl.electronics_reset = (n.st == MPSM_RESET) || (n.st == MPSM_RESETTING);
        n.ctl.host_irq_block    = (n.st == MPSM_RESET) || (n.st == MPSM_RESETTING)
                                  || (n.st == MPSM_INIT);
        n.ctl.path_deactivated  = (n.st != MPSM_READY);
        n.ctl.path_discard      = (n.st == MPSM_RESETTING) && (r.st != MPSM_RESETTING);
        n.ctl.mgmt_link_ready   = (n.st == MPSM_LOWPWR) || (n.st == MPSM_PWRUP)
                                  || (n.st == MPSM_READY) || (n.st == MPSM_PWRDN);
        n.ctl.state_change_flag = n.flag;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------

    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            r <= '{rst_s: 2'h0, lp_s: 2'h0, lpx_s: 2'h0, pwr_s: 2'h0, lclk_s: 3'h0,
                   st: MPSM_RESET, cnt: 16'h0000, flag: 1'b0, soft_rst: 1'b0,
                   link_cnt: 8'h00, rdata: 32'h0000_0000,
                   ctl: '{module_state: `MPSM_CODE_RESET, high_power_en: 1'b0,
                          electronics_reset: 1'b1, path_deactivated: 1'b1,
                          path_discard: 1'b0, mgmt_link_ready: 1'b0,
                          host_irq_block: 1'b1, state_change_flag: 1'b0}};
        end else begin
            r <= n;
        end
    end

    assign rdata = r.rdata;
    assign ctl   = r.ctl;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_q);

    sequence s_enter_low_held;
        r.st != MPSM_LOWPWR && n.st == MPSM_LOWPWR && lp_term;
    endsequence

    sequence s_enter_resetting;
        r.st != MPSM_RESETTING && n.st == MPSM_RESETTING;
    endsequence

    property p_reset_req;
        rst_term && r.st != MPSM_RESET && r.st != MPSM_RESETTING |=> r.st == MPSM_RESETTING;
    endproperty
    a_reset_req: assert property (p_reset_req) else $error("reset request ignored");

    property p_discard;
        s_enter_resetting |=> ctl.path_discard ##1 !ctl.path_discard;
    endproperty
    a_discard: assert property (p_discard) else $error("no discard pulse");

    property p_shutdown_done;
        r.st == MPSM_RESETTING && r.cnt == 16'h0000 |=> r.st == MPSM_RESET;
    endproperty
    a_shutdown_done: assert property (p_shutdown_done) else $error("stuck resetting");

    property p_soft_clear;
        r.st == MPSM_RESET ##1 r.st == MPSM_RESET |-> !r.soft_rst;
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("soft reset kept");

    property p_reset_hold;
        r.st == MPSM_RESET |-> ctl.electronics_reset && !ctl.high_power_en
                               && ctl.host_irq_block && !ctl.mgmt_link_ready;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("reset outputs wrong");

    property p_reset_exit;
        r.st == MPSM_RESET && !r.rst_s[1] && r.pwr_s[1] |=> r.st == MPSM_INIT;
    endproperty
    a_reset_exit: assert property (p_reset_exit) else $error("reset exit wrong");

    property p_low_flag;
        s_enter_low_held |=> r.flag && ctl.module_state == `MPSM_CODE_LOWPWR;
    endproperty
    a_low_flag: assert property (p_low_flag) else $error("low entry flag missing");

    property p_pwrup_go;
        r.st == MPSM_LOWPWR && !lp_term && !rst_term |=> r.st == MPSM_PWRUP
            ##1 ctl.module_state == `MPSM_CODE_PWRUP || r.st != MPSM_PWRUP;
    endproperty
    a_pwrup_go: assert property (p_pwrup_go) else $error("no power up");

    property p_pwrup_abort;
        r.st == MPSM_PWRUP && lp_term && !rst_term |=> r.st == MPSM_PWRDN;
    endproperty
    a_pwrup_abort: assert property (p_pwrup_abort) else $error("abort ignored");

    property p_ready_flag;
        r.st == MPSM_PWRUP ##1 r.st == MPSM_READY |-> r.flag && ctl.high_power_en;
    endproperty
    a_ready_flag: assert property (p_ready_flag) else $error("ready flag missing");

    property p_pwrdn_ignore;
        r.st == MPSM_PWRDN && r.cnt != 16'h0000 && !rst_term |=> r.st == MPSM_PWRDN;
    endproperty
    a_pwrdn_ignore: assert property (p_pwrdn_ignore) else $error("left power down early");

    property p_low_power;
        r.st != MPSM_PWRUP && r.st != MPSM_READY |-> !ctl.high_power_en;
    endproperty
    a_low_power: assert property (p_low_power) else $error("high power outside ready");

    property p_pwrup_paths;
        r.st == MPSM_PWRUP |-> ctl.path_deactivated && ctl.module_state == `MPSM_CODE_PWRUP;
    endproperty
    a_pwrup_paths: assert property (p_pwrup_paths) else $error("pwrup paths wrong");

    property p_pwrdn_paths;
        r.st == MPSM_PWRDN |-> ctl.path_deactivated && ctl.module_state == `MPSM_CODE_PWRDN;
    endproperty
    a_pwrdn_paths: assert property (p_pwrdn_paths) else $error("pwrdn paths wrong");

    property p_init_paths;
        r.st == MPSM_INIT |-> ctl.path_deactivated && !ctl.high_power_en
                              && !ctl.mgmt_link_ready;
    endproperty
    a_init_paths: assert property (p_init_paths) else $error("init outputs wrong");

    property p_init_exit;
        r.st == MPSM_INIT && r.cnt == 16'h0000 && !rst_term |=> r.st == MPSM_LOWPWR;
    endproperty
    a_init_exit: assert property (p_init_exit) else $error("init did not finish");

    property p_init_defaults;
        r.st == MPSM_INIT ##1 r.st == MPSM_INIT |-> !r.flag && !r.soft_rst
                                                    && r.link_cnt == 8'h00;
    endproperty
    a_init_defaults: assert property (p_init_defaults) else $error("defaults not loaded");

    property p_ready_hold;
        r.st == MPSM_READY && !lpx_term && !rst_term |=> r.st == MPSM_READY;
    endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("left ready early");

    property p_quiet_read;
        !resp |=> rdata == 32'h0000_0000;
    endproperty
    a_quiet_read: assert property (p_quiet_read) else $error("read answered while quiet");

    property p_link_quiet;
        r.st == MPSM_RESET |-> !ctl.mgmt_link_ready && !resp;
    endproperty
    a_link_quiet: assert property (p_link_quiet) else $error("link live in reset");

endmodule : mpsm_module_state_machine
`default_nettype wire

// File: mpsm_map.svh
// Offsets, field positions, reset values and timing counts of the module state machine
`ifndef MPSM_MAP_SVH
`define MPSM_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MPSM_OFS_STATE    8'h00
`define MPSM_OFS_FLAG     8'h04
`define MPSM_OFS_CTRL     8'h08
`define MPSM_OFS_MAXPWR   8'h0C
`define MPSM_OFS_LINK     8'h10

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define MPSM_FLAG_CHG_BIT 0
`define MPSM_CTRL_SRST_BIT 0
`define MPSM_MAXPWR_RST   8'h00

// ----------------------------------------
// Reported state codes
// ----------------------------------------
`define MPSM_CODE_RESETTING 3'h0
`define MPSM_CODE_RESET     3'h0
`define MPSM_CODE_INIT      3'h0
`define MPSM_CODE_LOWPWR    3'h1
`define MPSM_CODE_PWRUP     3'h2
`define MPSM_CODE_READY     3'h3
`define MPSM_CODE_PWRDN     3'h4

// ----------------------------------------
// Timing: times in ns, counts in 5 ns cycles
// ----------------------------------------
`define MPSM_CLK_NS        5
`define MPSM_T_SHUTDOWN_NS 1000
`define MPSM_T_INIT_NS     2000
`define MPSM_T_PWRUP_NS    1000
`define MPSM_T_PWRDN_NS    1000
`define MPSM_CYC(ns) (16'(((ns) + `MPSM_CLK_NS - 1) / `MPSM_CLK_NS))

`endif

// File: mpsm_pkg.sv
// Types shared by the module state machine
`default_nettype none
package mpsm_pkg;

    // One-hot states of the module state machine
    typedef enum logic [6:0] {
        MPSM_RESETTING = 7'h01,
        MPSM_RESET     = 7'h02,
        MPSM_INIT      = 7'h04,
        MPSM_LOWPWR    = 7'h08,
        MPSM_PWRUP     = 7'h10,
        MPSM_READY     = 7'h20,
        MPSM_PWRDN     = 7'h40
    } mpsm_state_e;

    // Register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } mpsm_req_s;

    // Host-side request pins
    typedef struct packed {
        logic reset_request_term;
        logic low_power_request_term;
        logic low_power_exit_request_term;
        logic power_good;
        logic link_clk;
    } mpsm_pins_s;

    // Control outputs toward the module electronics
    typedef struct packed {
        logic [2:0] module_state;
        logic       high_power_en;
        logic       electronics_reset;
        logic       path_deactivated;
        logic       path_discard;
        logic       mgmt_link_ready;
        logic       host_irq_block;
        logic       state_change_flag;
    } mpsm_ctl_s;

endpackage : mpsm_pkg
`default_nettype wire

// File: mpsm_link_host.sv
// Host-side management link clock source for the module state machine bench
`timescale 1ns/100ps
`default_nettype none

module mpsm_link_host (
    input  wire logic       go,
    input  wire logic [7:0] rises,
    output var  logic       link_clk,
    output var  logic       busy
);
    // One frame of link clock rises per request; the clock rests low between frames
    initial begin
        link_clk = 1'b0;
        busy     = 1'b0;
        forever begin
            @(posedge go);
            busy = 1'b1;
            #1.7;
            repeat (rises) begin
                #80 link_clk = 1'b1;
                #80 link_clk = 1'b0;
            end
            busy = 1'b0;
        end
    end
endmodule : mpsm_link_host
`default_nettype wire

// File: test_module_power_state_machine.sv
// Self-checking bench of the module state machine
`include "mpsm_map.svh"
`timescale 1ns/100ps
`default_nettype none

module test_module_power_state_machine;
    import mpsm_pkg::*;
    logic        clk, rst_n, rst_t, lp_t, ex_t, pg, go;
    logic [7:0]  rises, cnt0;
    logic [15:0] lfsr;
    logic [31:0] rdata, rd_val;
    wire logic   link_clk, busy;
    mpsm_pins_s  pins;
    mpsm_req_s   req;
    mpsm_ctl_s   ctl;
    int          mismatches, checks_done, discards;

    assign pins = {rst_t, lp_t, ex_t, pg, link_clk};
    mpsm_module_state_machine dut (.clk(clk), .rst_n(rst_n), .pins(pins), .req(req),
                                   .rdata(rdata), .ctl(ctl));
    mpsm_link_host host (.go(go), .rises(rises), .link_clk(link_clk), .busy(busy));

    // ----------------------------------------
    // Clock, pulse counter and watchdog
    // ----------------------------------------
    initial clk = 1'b0;
    always #2.5 clk = ~clk;
    // Count discard pulses toward the data paths
    always @(posedge clk) if (ctl.path_discard === 1'b1) discards++;
    // Cut a hang short
    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge clk);
        req.wr    <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a);
        @(posedge clk);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge clk);
        req.rd   <= 1'b0;
        #1 rd_val = rdata;
    endtask : bus_rd
    task automatic wait_code(input logic [2:0] c, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge clk);
            #1;
            if (ctl.module_state === c) break;
        end
        check("module_state", 32'(ctl.module_state), 32'(c));
    endtask : wait_code
    task automatic wait_ereset(input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge clk);
            #1;
            if (ctl.electronics_reset === 1'b1) break;
        end
        check("electronics_reset", 32'(ctl.electronics_reset), 32'h1);
    endtask : wait_ereset
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst_n, rst_t, ex_t, pg, go, rises} = '0;
        lp_t = 1'b1;
        req  = '0;
        lfsr = 16'h5C01;
        {mismatches, checks_done, discards} = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        // Power not applied: the machine stays in Reset
        cycles(60);
        check("electronics_reset", 32'(ctl.electronics_reset), 32'h1);
        check("irq_block", 32'(ctl.host_irq_block), 32'h1);
        check("high_power_en", 32'(ctl.high_power_en), 32'h0);
        bus_rd(`MPSM_OFS_STATE);
        check("rd_in_reset", rd_val, 32'h0);
        pg <= 1'b1;
        // Init completes into the basic low-power state with the flag raised
        wait_code(`MPSM_CODE_LOWPWR, 600);
        check("flag", 32'(ctl.state_change_flag), 32'h1);
        check("path_deact", 32'(ctl.path_deactivated), 32'h1);
        check("high_power_en", 32'(ctl.high_power_en), 32'h0);
        bus_rd(`MPSM_OFS_STATE);
        check("state_reg", rd_val, 32'(`MPSM_CODE_LOWPWR));
        bus_rd(`MPSM_OFS_MAXPWR);
        check("max_power", rd_val, 32'(`MPSM_MAXPWR_RST));
        for (int i = 0; i < 3; i++) begin
            lfsr = lfsr_next(lfsr);
            bus_rd(8'h20 | lfsr[7:0]);
            check("unmapped", rd_val, 32'h0);
        end
        bus_wr(`MPSM_OFS_FLAG, 32'h1 << `MPSM_FLAG_CHG_BIT);
        bus_rd(`MPSM_OFS_FLAG);
        check("flag_clear", rd_val, 32'h0);
        // Link frame of random length is counted
        lfsr = lfsr_next(lfsr);
        rises <= 8'(lfsr[3:0]) + 8'h1;
        bus_rd(`MPSM_OFS_LINK);
        cnt0 = rd_val[7:0];
        go <= 1'b1;
        cycles(2);
        for (int i = 0; i < 800 && busy !== 1'b0; i++) cycles(1);
        go <= 1'b0;
        cycles(4);
        bus_rd(`MPSM_OFS_LINK);
        check("link_rises", 32'(8'(rd_val[7:0] - cnt0)), 32'(rises));
        // Power up, then abort at once on a new low power request
        lp_t <= 1'b0;
        wait_code(`MPSM_CODE_PWRUP, 8);
        check("path_deact", 32'(ctl.path_deactivated), 32'h1);
        check("high_power_en", 32'(ctl.high_power_en), 32'h1);
        lp_t <= 1'b1;
        wait_code(`MPSM_CODE_PWRDN, 6);
        check("path_deact", 32'(ctl.path_deactivated), 32'h1);
        // Request withdrawn while powering down is ignored until low power
        lp_t <= 1'b0;
        cycles(100);
        check("pwrdn_hold", 32'(ctl.module_state), 32'(`MPSM_CODE_PWRDN));
        wait_code(`MPSM_CODE_LOWPWR, 150);
        wait_code(`MPSM_CODE_PWRUP, 5);
        check("flag_kept", 32'(ctl.state_change_flag), 32'h0);
        wait_code(`MPSM_CODE_READY, 250);
        check("flag", 32'(ctl.state_change_flag), 32'h1);
        check("path_deact", 32'(ctl.path_deactivated), 32'h0);
        // Operational ignores low power request, leaves on exit request
        lp_t <= 1'b1;
        cycles(20);
        check("ready_hold", 32'(ctl.module_state), 32'(`MPSM_CODE_READY));
        ex_t <= 1'b1;
        wait_code(`MPSM_CODE_PWRDN, 6);
        ex_t <= 1'b0;
        wait_code(`MPSM_CODE_LOWPWR, 250);
        // Reset request while powering up
        lp_t <= 1'b0;
        wait_code(`MPSM_CODE_PWRUP, 8);
        rst_t <= 1'b1;
        wait_ereset(8);
        check("link_ready", 32'(ctl.mgmt_link_ready), 32'h0);
        bus_rd(`MPSM_OFS_STATE);
        check("rd_in_resetting", rd_val, 32'h0);
        cycles(400);
        check("discards", 32'(discards), 32'h1);
        check("held_reset", 32'(ctl.electronics_reset), 32'h1);
        lp_t  <= 1'b1;
        rst_t <= 1'b0;
        wait_code(`MPSM_CODE_LOWPWR, 700);
        // Soft reset bit acts as reset request and clears itself
        bus_wr(`MPSM_OFS_CTRL, 32'h1 << `MPSM_CTRL_SRST_BIT);
        wait_ereset(10);
        wait_code(`MPSM_CODE_INIT, 300);
        wait_code(`MPSM_CODE_LOWPWR, 500);
        bus_rd(`MPSM_OFS_CTRL);
        check("soft_reset", rd_val, 32'h0);
        check("discards", 32'(discards), 32'h2);
        give_verdict();
    end
endmodule : test_module_power_state_machine
`default_nettype wire
